// file: gong_tone_generator_tb_top.sv
// Self-checking bench for the gong tone generator and its speaker.
// Assumes gtg_pkg, gtg_top and gtg_speaker are compiled first.
`timescale 1ns/1ps

module gong_tone_generator_tb_top;
  localparam int PRE  = 3;
  localparam int DIV  = 1;
  localparam int HALF = (DIV + 1) * (PRE + 1);
  logic        clk, rst, module_clock, wr, rd, tone_out, half_rate;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, got;
  logic [31:0] energy, e0, e;
  logic [15:0] last_run;
  logic [18:0] rows [7];
  int          n_errors, tests_run;

  gtg_top uut (.clk(clk), .rst(rst), .module_clock(module_clock),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tone_out(tone_out));
  gtg_speaker spk (.clk(clk), .rst(rst), .tone_in(tone_out),
    .energy(energy), .last_run(last_run));

  // Free-running 25 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Clock option tick: every cycle, or every other one at half rate.
  always @(posedge clk)
    module_clock <= half_rate ? ~module_clock : 1'b1;

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd_chk(string what, logic [2:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 got = rdata;
    check(what, {24'h0, exp}, {24'h0, got});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // High cycles the speaker saw over a window of n cycles.
  task automatic hum(input int n);
    @(posedge clk);
    #1 e0 = energy;
    repeat (n) @(posedge clk);
    #1 e = energy - e0;
  endtask

  task automatic conclude;
    $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang would otherwise run forever; the tests need about 5400 cycles.
  initial
  begin
    #(40 * 20000);
    n_errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {half_rate, wr, rd, addr, wdata} = '0;
    rows[0] = {3'h5, 8'h5A, 8'h00};
    rows[1] = {gtg_pkg::ADDR_PRE, 8'(PRE), 8'(PRE)};
    rows[2] = {gtg_pkg::ADDR_AMPL, 8'h37, 8'h80};
    rows[3] = {gtg_pkg::ADDR_AMPL, 8'h00, 8'h00};
    rows[4] = {3'h7, 8'hFF, 8'h00};
    rows[5] = {gtg_pkg::ADDR_DIV, 8'h85, 8'h05};
    rows[6] = {gtg_pkg::ADDR_DECAY, 8'hFA, 8'h82};
    cyc(12);
    rst <= 1'b0;
    rd_chk("pre reset", gtg_pkg::ADDR_PRE, gtg_pkg::RST_PRE);
    rd_chk("status reset", gtg_pkg::ADDR_AMPL, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(rows[i][18:16], rows[i][15:8]);
      rd_chk("table", rows[i][18:16], rows[i][7:0]);
    end
    // Full duty, continuous tone: frequency and gating.
    wr_reg(gtg_pkg::ADDR_DIV, 8'(DIV));
    wr_reg(gtg_pkg::ADDR_DECAY, 8'h06);
    wr_reg(gtg_pkg::ADDR_AMPL, 8'hFF);
    cyc(40);
    check("high run", HALF, 32'(last_run));
    hum(8 * HALF);
    check("full duty", 4 * HALF, e);
    half_rate <= 1'b1;
    cyc(80);
    check("half rate run", 2 * HALF, 32'(last_run));
    half_rate <= 1'b0;
    cyc(40);
    // Restart at the start of a high half must fall back to a low half.
    // Look just after each edge so the pin has already settled.
    #1;
    for (int k = 0; k < 16 && tone_out !== 1'b0; k++) @(posedge clk) #1;
    for (int k = 0; k < 16 && tone_out !== 1'b1; k++) @(posedge clk) #1;
    wr_reg(gtg_pkg::ADDR_AMPL, 8'hFF);
    cyc(2);
    for (int i = 0; i < 5; i++)
    begin
      #1 check("restart low", 32'h0, {31'h0, tone_out});
      @(posedge clk);
    end
    // Partial duty, then constant maximum mode.
    wr_reg(gtg_pkg::ADDR_AMPL, 8'h01);
    cyc(16);
    hum(8 * HALF);
    check("duty amp 1", 4 * HALF * 2 / (PRE + 1), e);
    wr_reg(gtg_pkg::ADDR_DECAY, 8'h86);
    wr_reg(gtg_pkg::ADDR_AMPL, 8'h01);
    cyc(16);
    hum(8 * HALF);
    check("const max", 4 * HALF, e);
    wr_reg(gtg_pkg::ADDR_DIV, 8'h03);
    cyc(80);
    check("new divider", 4 * (PRE + 1), 32'(last_run));
    cyc(1000);
    rd_chk("continuous", gtg_pkg::ADDR_AMPL, 8'h80);
    wr_reg(gtg_pkg::ADDR_AMPL, 8'h00);
    rd_chk("stop flag", gtg_pkg::ADDR_AMPL, 8'h00);
    hum(64);
    check("silent", 32'h0, e);
    // One decrement ends amplitude 1; gong period is 2*(PRE+1).
    wr_reg(gtg_pkg::ADDR_DIV, 8'h00);
    for (int g = 0; g < 6; g++)
    begin
      wr_reg(gtg_pkg::ADDR_DECAY, 8'(g));
      wr_reg(gtg_pkg::ADDR_AMPL, 8'h01);
      cyc(((2 ** g) + 1) * 2 * (PRE + 1) + 8);
      rd_chk("decay stop", gtg_pkg::ADDR_AMPL, 8'h00);
    end
    // Full scale takes 193 decrements, here one every two gong cycles.
    wr_reg(gtg_pkg::ADDR_DECAY, 8'h01);
    wr_reg(gtg_pkg::ADDR_AMPL, 8'hFF);
    cyc(193 * 2 * 2 * (PRE + 1) - 40);
    rd_chk("still decaying", gtg_pkg::ADDR_AMPL, 8'h80);
    cyc(80);
    rd_chk("decayed", gtg_pkg::ADDR_AMPL, 8'h00);
    check("pin idle", 32'h0, {31'h0, tone_out});
    // Reset in the middle of a tone must silence it and restore defaults.
    wr_reg(gtg_pkg::ADDR_AMPL, 8'hFF);
    cyc(4);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    #1 check("reset silences", 32'h0, {31'h0, tone_out});
    rd_chk("mid reset pre", gtg_pkg::ADDR_PRE, gtg_pkg::RST_PRE);
    rd_chk("mid reset flag", gtg_pkg::ADDR_AMPL, 8'h00);
    conclude();
  end
endmodule

// file: gtg_pkg.sv
// Package for the gong tone generator: register map, fields, reset values.
// Assumes a single clock domain and the plain register port of the core.
package gtg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_AMPL   = 3'h0;
  localparam logic [2:0] ADDR_DIV    = 3'h1;
  localparam logic [2:0] ADDR_DECAY  = 3'h2;
  localparam logic [2:0] ADDR_PRE    = 3'h3;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         DEC_CMAX_BIT = 7;
  localparam int         DEC_GDF_LSB  = 0;
  localparam logic [7:0] RST_PRE      = 8'hFF;
  localparam logic [6:0] RST_DIV      = 7'h00;
  localparam logic [2:0] RST_GDF      = 3'h0;
  localparam logic [2:0] GDF_MAX_DEC  = 3'h5;
  localparam int         LATCH_W      = 13;
  localparam int         FRAC_W       = 5;

  // Decay settings travel together.
  typedef struct packed {
    logic       cmax;
    logic [2:0] duration_factor;
  } gtg_decay_t;

endpackage

// file: gtg_speaker.sv
// Speaker driver model listening on the gong output pin.
// Assumes the pin is a registered level in the clk domain.
`timescale 1ns/1ps

module gtg_speaker
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tone_in,
  output logic      [31:0] energy,
  output logic      [15:0] last_run
);
  logic [15:0] run;

  // The cone integrates drive time only; it never loads the pin back.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      energy   <= '0;
      run      <= '0;
      last_run <= '0;
    end
    else
    begin
      energy <= energy + 32'(tone_in);
      run    <= tone_in ? run + 16'h0001 : 16'h0000;
      if (!tone_in && run != 16'h0000)
        last_run <= run;
    end
  end
endmodule

// file: gtg_top.sv
// Gong tone generator: prescaler, tone divider, decay accumulator, PWM.
// Assumes module_clock is a synchronous one-cycle enable from clock options.
//
// Operation
// - Trigger is module clock over prescaler+1; gong over 2*(divider+1).
// - Duty about (amp+1)/(pre+1); full while amplitude at or above prescaler.
// - Amplitude write loads initial amplitude and starts; active flag reads.
// - Active flag set in the write cycle; it enables the module clock.
// - New amplitude every 2^factor gong cycles, factor 0 to 5.
// - Decrement edge latches 13-bit sum and loads upper eight bits to PWM.
// - New amplitude used in low half, seen at output from next high half.
// - Output pin is PWM gated by gong square wave.
// - Each decrement subtracts one thirty-second of the current amplitude.
// - Upper eight latch bits zero clears active flag and stops tone.
// - Non-zero write restarts immediately, beginning with a low half-cycle.
// - Running amplitude is not readable by software.
// - Writing zero stops tone and clears active flag in that cycle.
// - Factor 6 or 7 disables decay; tone stops only by zero write.
// - Module clock rate chosen by hardware option, not a register.
// - Constant-maximum mode gives full amplitude; value sets duration only.
// - Divider and factor changes apply while active, tone continues.
// - Prescaler register is eight bits, reset to all ones.
`timescale 1ns/1ps

module gtg_top
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       module_clock,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            tone_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic                      tone_active_flag;
  logic [7:0]                trigger_prescaler;
  logic [6:0]                tone_divider;
  gtg_pkg::gtg_decay_t       decay_control_reg;
  logic [gtg_pkg::LATCH_W-1:0] amp_latch;
  logic [7:0]                pwm_value;
  logic [7:0]                pre_cnt;
  logic [6:0]                div_cnt;
  logic                      gong;
  logic [4:0]                dec_cnt;
  logic [7:0]                pwm_cnt;
  logic                      pwm_level;

  logic                      next_active;
  logic [7:0]                next_pre;
  logic [6:0]                next_div;
  gtg_pkg::gtg_decay_t       next_decay;
  logic [gtg_pkg::LATCH_W-1:0] next_latch;
  logic [7:0]                next_pwm_value;
  logic [7:0]                next_pre_cnt;
  logic [6:0]                next_div_cnt;
  logic                      next_gong;
  logic [4:0]                next_dec_cnt;
  logic [7:0]                next_pwm_cnt;
  logic                      next_pwm_level;
  logic [7:0]                next_rdata;
  logic                      next_tone_out;

  logic                      wr_ampl;
  logic                      trig;
  logic                      gong_fall;
  logic                      dec_strobe;
  logic [4:0]                dec_period_m1;
  logic [gtg_pkg::LATCH_W-1:0] dec_sum;

  // ----------------------------------------------------------------------
  // Timing terms
  // ----------------------------------------------------------------------
  // Module clock only counts while active, which gates the whole chain.
  // The tick rate itself is fixed outside by the clock option setting.
  // Counters end at or above their limit, so a smaller limit written
  // mid-tone takes effect at once instead of wrapping the counter.
  assign wr_ampl   = wr && (addr == gtg_pkg::ADDR_AMPL);
  assign trig      = tone_active_flag && module_clock &&
                     (pre_cnt >= trigger_prescaler);
  assign gong_fall = trig && gong && (div_cnt >= tone_divider);
  assign dec_period_m1 = 5'((6'h01 << decay_control_reg.duration_factor) - 6'h01);
  // Factors above five leave the counter running but never strobe.
  assign dec_strobe = gong_fall &&
                      (decay_control_reg.duration_factor <= gtg_pkg::GDF_MAX_DEC) &&
                      (dec_cnt == dec_period_m1);
  // Subtract the latch shifted by five: one thirty-second per step.
  assign dec_sum = amp_latch -
                   (amp_latch >> gtg_pkg::FRAC_W);

  // ----------------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------------
  // An amplitude write outranks the decay step in the same cycle, since a
  // restart must discard whatever amplitude was running.
  always_comb
  begin
    next_active    = tone_active_flag;
    next_pre       = trigger_prescaler;
    next_div       = tone_divider;
    next_decay     = decay_control_reg;
    next_latch     = amp_latch;
    next_pwm_value = pwm_value;
    next_pre_cnt   = pre_cnt;
    next_div_cnt   = div_cnt;
    next_gong      = gong;
    next_dec_cnt   = dec_cnt;
    next_pwm_cnt   = pwm_cnt;
    next_pwm_level = pwm_level;
    next_rdata     = 8'h00;

    if (tone_active_flag && module_clock)
    begin
      next_pre_cnt = trig ? 8'h00 : pre_cnt + 8'h01;
    end
    if (trig)
    begin
      // PWM period equals the trigger period: one slot per module clock.
      next_pwm_cnt = 8'h00;
      if (div_cnt >= tone_divider)
      begin
        next_div_cnt = 7'h00;
        next_gong    = !gong;
        if (gong_fall)
        begin
          next_dec_cnt = (dec_cnt >= dec_period_m1) ? 5'h00
                                                    : dec_cnt + 5'h01;
        end
      end
      else
      begin
        next_div_cnt = div_cnt + 7'h01;
      end
    end
    else if (tone_active_flag && module_clock)
    begin
      next_pwm_cnt = pwm_cnt + 8'h01;
    end
    // Full level while the amplitude sits at or above the prescaler.
    if (tone_active_flag && module_clock)
    begin
      next_pwm_level = decay_control_reg.cmax ||
                       (pwm_value >= trigger_prescaler) ||
                       (next_pwm_cnt <= pwm_value);
    end
    if (dec_strobe)
    begin
      next_latch     = dec_sum;
      next_pwm_value = dec_sum[gtg_pkg::LATCH_W-1:gtg_pkg::FRAC_W];
      if (dec_sum[gtg_pkg::LATCH_W-1:gtg_pkg::FRAC_W] == 8'h00)
      begin
        next_active = 1'b0;
      end
    end

    if (wr)
    begin
      unique case (addr)
        gtg_pkg::ADDR_DIV:   next_div = wdata[6:0];
        gtg_pkg::ADDR_DECAY:
        begin
          next_decay.cmax = wdata[gtg_pkg::DEC_CMAX_BIT];
          next_decay.duration_factor  = wdata[gtg_pkg::DEC_GDF_LSB +: 3];
        end
        gtg_pkg::ADDR_PRE:   next_pre = wdata;
        default:             ;
      endcase
    end
    if (wr_ampl)
    begin
      // Restart begins in the low half with all counters cleared.
      next_active    = (wdata != 8'h00);
      next_latch     = {wdata, 5'h00};
      next_pwm_value = wdata;
      next_pre_cnt   = 8'h00;
      next_div_cnt   = 7'h00;
      next_gong      = 1'b0;
      next_dec_cnt   = 5'h00;
      next_pwm_cnt   = 8'h00;
      next_pwm_level = 1'b0;
    end

    // Only the active flag is visible; the decayed amplitude is hidden.
    if (rd)
    begin
      unique case (addr)
        gtg_pkg::ADDR_AMPL:  next_rdata = {tone_active_flag, 7'h00};
        gtg_pkg::ADDR_DIV:   next_rdata = {1'b0, tone_divider};
        gtg_pkg::ADDR_DECAY: next_rdata = {decay_control_reg.cmax, 4'h0,
                                           decay_control_reg.duration_factor};
        gtg_pkg::ADDR_PRE:   next_rdata = trigger_prescaler;
        default:             next_rdata = 8'h00;
      endcase
    end

    // Gate the PWM with the square wave; silent when stopped.
    next_tone_out = next_active && next_gong && next_pwm_level;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tone_active_flag  <= 1'b0;
      trigger_prescaler <= gtg_pkg::RST_PRE;
      tone_divider      <= gtg_pkg::RST_DIV;
      decay_control_reg <= '{cmax: 1'b0, duration_factor: gtg_pkg::RST_GDF};
      amp_latch         <= '0;
      pwm_value         <= 8'h00;
      pre_cnt           <= 8'h00;
      div_cnt           <= 7'h00;
      gong              <= 1'b0;
      dec_cnt           <= 5'h00;
      pwm_cnt           <= 8'h00;
      pwm_level         <= 1'b0;
      rdata             <= 8'h00;
      tone_out          <= 1'b0;
    end
    else
    begin
      tone_active_flag  <= next_active;
      trigger_prescaler <= next_pre;
      tone_divider      <= next_div;
      decay_control_reg <= next_decay;
      amp_latch         <= next_latch;
      pwm_value         <= next_pwm_value;
      pre_cnt           <= next_pre_cnt;
      div_cnt           <= next_div_cnt;
      gong              <= next_gong;
      dec_cnt           <= next_dec_cnt;
      pwm_cnt           <= next_pwm_cnt;
      pwm_level         <= next_pwm_level;
      rdata             <= next_rdata;
      tone_out          <= next_tone_out;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_start;
    wr_ampl && (wdata != 8'h00);
  endsequence

  // A decrement step that no amplitude write overrides.
  sequence s_step;
    dec_strobe && !wr_ampl;
  endsequence

  AST_START: assert property (@(posedge clk) disable iff (rst)
    s_start |=> tone_active_flag && !gong)
    else $error("Start write did not activate in low half.");

  AST_STOP: assert property (@(posedge clk) disable iff (rst)
    wr_ampl && (wdata == 8'h00) |=> !tone_active_flag && !tone_out)
    else $error("Zero write did not stop the tone.");

  AST_IDLE_LOW: assert property (@(posedge clk) disable iff (rst)
    !tone_active_flag |-> !tone_out)
    else $error("Tone output high while inactive.");

  AST_GATE: assert property (@(posedge clk) disable iff (rst)
    tone_out |-> gong)
    else $error("Tone output high in low gong half.");

  AST_DECAY: assert property (@(posedge clk) disable iff (rst)
    dec_strobe && !wr_ampl |=> amp_latch == $past(dec_sum))
    else $error("Decay step wrong.");

  AST_NO_DECAY: assert property (@(posedge clk) disable iff (rst)
    decay_control_reg.duration_factor > gtg_pkg::GDF_MAX_DEC |-> !dec_strobe)
    else $error("Decay ran with continuous factor.");

  AST_END: assert property (@(posedge clk) disable iff (rst)
    dec_strobe && !wr_ampl &&
    (dec_sum[gtg_pkg::LATCH_W-1:gtg_pkg::FRAC_W] == 8'h00)
    |=> !tone_active_flag)
    else $error("Zero amplitude did not end the tone.");

  AST_READ: assert property (@(posedge clk) disable iff (rst)
    rd && (addr == gtg_pkg::ADDR_AMPL) |=>
    rdata == {$past(tone_active_flag), 7'h00})
    else $error("Amplitude read exposed more than the flag.");

  AST_PRE: assert property (@(posedge clk) disable iff (rst)
    trig |=> pre_cnt == 8'h00)
    else $error("Prescaler did not wrap on trigger.");

  AST_SAT: assert property (@(posedge clk) disable iff (rst)
    tone_active_flag && module_clock && !wr_ampl &&
    (pwm_value >= trigger_prescaler) |=> pwm_level)
    else $error("Saturated amplitude did not give full duty.");

  AST_LOAD: assert property (@(posedge clk) disable iff (rst)
    s_step |=> !gong &&
    (pwm_value == amp_latch[gtg_pkg::LATCH_W-1:gtg_pkg::FRAC_W]))
    else $error("Decrement did not load the PWM in a low half.");

endmodule
